/* verilog/fault_status_char_packer.sv */
/*
 * Packs live and stored fault conditions into the printable status characters
 * e through p of the bulk fault status response, one character per handshake.
 * Assumes an APB master, a serial framer that pulls characters with charReady,
 * and fault inputs synchronous to core_clk.
 */
// Function
// - Demod char 2: marker, IF synth b5, I b3, Q b2, BER b0.
// - Demod char 3: marker bit 6, bits 5..0 reserved zero.
// - TX char 1: marker, module fault b5, stored TX count 0..10 b3..0.
// - TX char 2: data/AIS, clock activity, synth, reference, PLL, drop on b5..0.
// - TX char 3: marker bit 6, bits 5..0 reserved zero.
// - RX char 1: marker, module fault b5, stored RX count 0..10 b3..0.
// - RX char 2: buffer PLL, buffer clock, data/AIS, demux, 2047 lock on b5..1.
// - RX char 3: underflow, overflow, full, insert, backward alarm, frame BER.
// - Common char 1: marker, M&C module fault b5, stored count 0..10.
// - Common char 2: battery/clock, -12, +12, +5, +3.3, +2.5 V on b5..0.
// - Common char 3: +1.8 V, temperature, reference PLL, activity; b1..0 reserved.
// - Each fault flag reads one while its fault is present, else zero.
// - Backward alarm char 1: marker, TX alarms 1 and 2, stored count.
`timescale 1ns/1ps
module fault_status_char_packer
    import fault_char_pkg::*;
#(
    parameter logic [CNT_WIDTH-1:0] MAX_STORED = STORED_MAX
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire demod_flt_s demodFlt,
    input wire tx_if_flt_s txIfFlt,
    input wire rx_if_flt_s rxIfFlt,
    input wire common_flt_s commonFlt,
    input wire bwd_alarm_s bwdAlarm,
    input wire store_evt_s storeEvt,
    output logic [CHAR_WIDTH-1:0] charData,
    output logic charValid,
    output logic charLast,
    input wire logic charReady,
    output logic irq
);

    // ==========================================================
    // APB slave: one wait-free access cycle, answer registered
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic wrEn;
    logic startReq;
    logic clearReq;
    logic [IRQ_WIDTH-1:0] irqStat_ff;
    logic [IRQ_WIDTH-1:0] irqMask_ff;
    logic [IRQ_WIDTH-1:0] irqSet;
    logic [IRQ_WIDTH-1:0] irqClr;
    logic irq_ff;
    seq_state_e state_ff;
    logic [IDX_WIDTH-1:0] idx_ff;
    logic [CNT_WIDTH-1:0] count [NUM_GROUPS];
    logic [NUM_GROUPS-1:0] incVec;

    // Write takes effect only at the edge that completes the access
    assign wrEn = psel & penable & pready_ff & pwrite;
    assign startReq = wrEn && paddr == OFS_CTRL && pwdata[CTRL_START_BIT];
    assign clearReq = wrEn && paddr == OFS_CTRL && pwdata[CTRL_CLEAR_BIT];
    assign irqClr = (wrEn && paddr == OFS_IRQ_STAT) ? pwdata[IRQ_WIDTH-1:0] : '0;

    // Read mux and unmapped-address error
    always_comb
    begin
        nxt_prdata = '0;
        nxt_pslverr = 1'b0;
        case (paddr)
            OFS_CTRL: nxt_prdata = '0;
            OFS_STATUS:
            begin
                nxt_prdata[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
                nxt_prdata[STAT_IDX_LSB +: IDX_WIDTH] = idx_ff;
            end
            OFS_IRQ_STAT: nxt_prdata[IRQ_WIDTH-1:0] = irqStat_ff;
            OFS_IRQ_MASK: nxt_prdata[IRQ_WIDTH-1:0] = irqMask_ff;
            OFS_COUNTS: nxt_prdata[NUM_GROUPS*CNT_WIDTH-1:0] =
                {count[GRP_BWD], count[GRP_COMMON], count[GRP_RX], count[GRP_TX]};
            default: nxt_pslverr = 1'b1;
        endcase
    end

    // Ready rises in the first access cycle, then drops for the next setup
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end
        else
        begin
            pready_ff <= psel & ~pready_ff;
            pslverr_ff <= psel & ~pready_ff & nxt_pslverr;
            prdata_ff <= (psel & ~pready_ff & ~pwrite) ? nxt_prdata : '0;
        end
    end

    // Mask register steers the interrupt output
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            irqMask_ff <= IRQ_MASK_RESET;
        else if (wrEn && paddr == OFS_IRQ_MASK)
            irqMask_ff <= pwdata[IRQ_WIDTH-1:0];
    end

    // ==========================================================
    // Stored fault counts, one saturating counter per group
    assign incVec = {storeEvt.bwd, storeEvt.common, storeEvt.rx, storeEvt.tx};

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++)
        begin : gCount
            stored_fault_counter #(
                .MAX_COUNT(MAX_STORED)
            ) uCount (
                .core_clk(core_clk),
                .resetn(resetn),
                .inc(incVec[g]),
                .clr(clearReq),
                .count(count[g])
            );
        end
    endgenerate

    // ==========================================================
    // Character images built from live flags, active high per fault
    logic [CHAR_WIDTH-1:0] liveChar [CHAR_COUNT];
    logic [CHAR_WIDTH-1:0] snapChar_ff [CHAR_COUNT];

    always_comb
    begin
        // e: demod character 2
        liveChar[0] = {MARKER, demodFlt.ifSynthLock, RSVD, demodFlt.iChannel,
                       demodFlt.qChannel, RSVD, demodFlt.berThreshold};
        // f: demod character 3
        liveChar[1] = {MARKER, {(CHAR_WIDTH-1){RSVD}}};
        // g: transmit interface character 1
        liveChar[2] = {MARKER, txIfFlt.moduleFault, RSVD, count[GRP_TX]};
        // h: transmit interface character 2
        liveChar[3] = {MARKER, txIfFlt.dataAis, txIfFlt.selClkActivity,
                       txIfFlt.internalTxClockSynthLock,
                       txIfFlt.internalTxClockRefActivity,
                       txIfFlt.txClkPll, txIfFlt.dropFault};
        // i: transmit interface character 3
        liveChar[4] = {MARKER, {(CHAR_WIDTH-1){RSVD}}};
        // j: receive interface character 1
        liveChar[5] = {MARKER, rxIfFlt.moduleFault, RSVD, count[GRP_RX]};
        // k: receive interface character 2
        liveChar[6] = {MARKER, rxIfFlt.bufClkPllLock, rxIfFlt.bufClkActivity,
                       rxIfFlt.dataAis, rxIfFlt.demuxLock,
                       rxIfFlt.patternLock, RSVD};
        // l: receive interface character 3
        liveChar[7] = {MARKER, rxIfFlt.bufUnderflow, rxIfFlt.bufOverflow,
                       rxIfFlt.bufFull, rxIfFlt.insertFault,
                       rxIfFlt.backwardAlarm, rxIfFlt.frameBer};
        // m: common equipment character 1
        liveChar[8] = {MARKER, commonFlt.mcModule, RSVD, count[GRP_COMMON]};
        // n: common equipment character 2
        liveChar[9] = {MARKER, commonFlt.batteryClock, commonFlt.neg12v,
                       commonFlt.pos12v, commonFlt.pos5v, commonFlt.pos3v3,
                       commonFlt.pos2v5};
        // o: common equipment character 3
        liveChar[10] = {MARKER, commonFlt.pos1v8, commonFlt.temperature,
                        commonFlt.refPll, commonFlt.refActivity,
                        RSVD, RSVD};
        // p: backward alarm character 1
        liveChar[11] = {MARKER, bwdAlarm.txAlarm1, bwdAlarm.txAlarm2,
                        count[GRP_BWD]};
    end

    // ==========================================================
    // Response sequencer
    seq_state_e nxt_state;
    logic accept;

    assign accept = charValid & charReady;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (startReq) nxt_state = ST_LOAD;
            ST_LOAD: nxt_state = ST_SEND;
            ST_SEND: if (accept && charLast) nxt_state = ST_FINISH;
            ST_FINISH: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // All characters captured on one edge so the response shows one instant
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < CHAR_COUNT; i++)
                snapChar_ff[i] <= CHAR_RESET;
        end
        else if (state_ff == ST_LOAD)
        begin
            for (int i = 0; i < CHAR_COUNT; i++)
                snapChar_ff[i] <= liveChar[i];
        end
    end

    // Character index walks e..p in letter order
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            idx_ff <= '0;
        else if (state_ff == ST_LOAD)
            idx_ff <= '0;
        else if (state_ff == ST_SEND && accept && !charLast)
            idx_ff <= idx_ff + IDX_WIDTH'(1);
    end

    // Output stage: valid held until the framer takes the character
    logic charValid_ff;
    logic charLast_ff;
    logic [CHAR_WIDTH-1:0] charData_ff;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            charValid_ff <= 1'b0;
            charLast_ff <= 1'b0;
            charData_ff <= CHAR_RESET;
        end
        else if (state_ff == ST_SEND && !(accept && charLast_ff))
        begin
            charValid_ff <= 1'b1;
            charData_ff <= snapChar_ff[accept ? idx_ff + IDX_WIDTH'(1) : idx_ff];
            charLast_ff <= (accept ? idx_ff + IDX_WIDTH'(1) : idx_ff)
                == IDX_WIDTH'(CHAR_COUNT - 1);
        end
        else
        begin
            charValid_ff <= 1'b0;
            charLast_ff <= 1'b0;
            charData_ff <= CHAR_RESET;
        end
    end

    // ==========================================================
    // Interrupts: response done and any live fault rising
    logic [LIVE_WIDTH-1:0] live;
    logic [LIVE_WIDTH-1:0] livePrev_ff;

    assign live = {demodFlt, txIfFlt, rxIfFlt, commonFlt, bwdAlarm};

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            livePrev_ff <= '0;
        else
            livePrev_ff <= live;
    end

    assign irqSet[IRQ_DONE_BIT] = (state_ff == ST_FINISH);
    assign irqSet[IRQ_RISE_BIT] = |(live & ~livePrev_ff);

    // Set beats a write-one clear landing in the same cycle
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irqStat_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
            irq_ff <= |(((irqStat_ff & ~irqClr) | irqSet) & irqMask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign charData = charData_ff;
    assign charValid = charValid_ff;
    assign charLast = charLast_ff;
    assign irq = irq_ff;

endmodule // fault_status_char_packer

/* verilog/fault_char_pkg.sv */
/*
 * Shared constants and carrier types for the fault status character packer.
 * Assumes one 10 MHz clock domain and a 32-bit APB master on the register side.
 */
package fault_char_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
    localparam logic [11:0] OFS_COUNTS = 12'h010;

    // ==========================================================
    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_IDX_LSB = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_RISE_BIT = 1;
    localparam int IRQ_WIDTH = 2;
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;

    // ==========================================================
    // Character format
    localparam int CHAR_WIDTH = 7;
    localparam int CHAR_COUNT = 12;
    localparam int IDX_WIDTH = 4;
    localparam int CNT_WIDTH = 4;
    localparam logic [CNT_WIDTH-1:0] STORED_MAX = 4'ha;
    localparam logic MARKER = 1'b1;
    localparam logic RSVD = 1'b0;
    localparam logic [CHAR_WIDTH-1:0] CHAR_RESET = 7'h00;
    localparam int NUM_GROUPS = 4;
    localparam int GRP_TX = 0;
    localparam int GRP_RX = 1;
    localparam int GRP_COMMON = 2;
    localparam int GRP_BWD = 3;
    localparam int LIVE_WIDTH = 36;

    // ==========================================================
    // Response sequencer states, Gray along idle-load-send-finish
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_SEND = 2'b11,
        ST_FINISH = 2'b10
    } seq_state_e;

    // ==========================================================
    // Live fault flag groups, one bit high while the fault is present
    typedef struct packed {
        logic ifSynthLock;
        logic iChannel;
        logic qChannel;
        logic berThreshold;
    } demod_flt_s;

    typedef struct packed {
        logic moduleFault;
        logic dataAis;
        logic selClkActivity;
        logic internalTxClockSynthLock;
        logic internalTxClockRefActivity;
        logic txClkPll;
        logic dropFault;
    } tx_if_flt_s;

    typedef struct packed {
        logic moduleFault;
        logic bufClkPllLock;
        logic bufClkActivity;
        logic dataAis;
        logic demuxLock;
        logic patternLock;
        logic bufUnderflow;
        logic bufOverflow;
        logic bufFull;
        logic insertFault;
        logic backwardAlarm;
        logic frameBer;
    } rx_if_flt_s;

    typedef struct packed {
        logic mcModule;
        logic batteryClock;
        logic neg12v;
        logic pos12v;
        logic pos5v;
        logic pos3v3;
        logic pos2v5;
        logic pos1v8;
        logic temperature;
        logic refPll;
        logic refActivity;
    } common_flt_s;

    typedef struct packed {
        logic txAlarm1;
        logic txAlarm2;
    } bwd_alarm_s;

    // One pulse per group when a new fault is stored
    typedef struct packed {
        logic tx;
        logic rx;
        logic common;
        logic bwd;
    } store_evt_s;

endpackage

/* verilog/stored_fault_counter.sv */
/*
 * Saturating count of stored faults for one fault group.
 * Assumes inc and clr are synchronous single-cycle pulses.
 */
`timescale 1ns/1ps
module stored_fault_counter
    import fault_char_pkg::*;
#(
    parameter logic [CNT_WIDTH-1:0] MAX_COUNT = STORED_MAX
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic inc,
    input wire logic clr,
    output logic [CNT_WIDTH-1:0] count
);

    logic [CNT_WIDTH-1:0] count_ff;

    // A store arriving with a clear still counts, so no fault goes unseen
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            count_ff <= '0;
        else if (inc)
        begin
            if (clr)
                count_ff <= CNT_WIDTH'(1);
            else if (count_ff < MAX_COUNT)
                count_ff <= count_ff + CNT_WIDTH'(1);
        end
        else if (clr)
            count_ff <= '0;
    end

    assign count = count_ff;

endmodule // stored_fault_counter

/* verif/fault_char_props.sv */
/* Concurrent checks on the status character stream of the packer.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module fault_char_props
    import fault_char_pkg::*;
#(
    parameter logic [CNT_WIDTH-1:0] MAX_STORED = STORED_MAX
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [CHAR_WIDTH-1:0] charData,
    input wire logic charValid,
    input wire logic charLast,
    input wire logic charReady
);
    logic [3:0] chIdx_ff;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // ==========================================================
    // Position of the offered character, counted from taken ones
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            chIdx_ff <= 4'h0;
        else if (charValid && charReady)
            chIdx_ff <= charLast ? 4'h0 : chIdx_ff + 4'h1;
    end

    // ==========================================================
    // Handshake steps
    sequence s_take;
        charValid && charReady;
    endsequence
    sequence s_start;
        psel && penable && pready && pwrite && paddr == OFS_CTRL
            && pwdata[CTRL_START_BIT] && !charValid;
    endsequence

    property p_marker;
        charValid |-> charData[6];
    endproperty
    property p_last;
        charValid |-> charLast == (chIdx_ff == 4'hb);
    endproperty
    property p_rsvdChar;
        charValid && (chIdx_ff == 4'h1 || chIdx_ff == 4'h4) |-> charData[5:0] == 6'h00;
    endproperty
    property p_demodRsvd;
        charValid && chIdx_ff == 4'h0 |-> !charData[4] && !charData[1];
    endproperty
    property p_tailRsvd;
        charValid |-> !(chIdx_ff == 4'h6 && charData[0])
            && !(chIdx_ff == 4'ha && charData[1:0] != 2'h0);
    endproperty
    property p_count;
        charValid && chIdx_ff inside {4'h2, 4'h5, 4'h8, 4'hb}
            |-> (chIdx_ff == 4'hb || !charData[4]) && charData[3:0] <= MAX_STORED;
    endproperty
    property p_hold;
        charValid && !charReady |=> charValid && $stable(charData) && $stable(charLast);
    endproperty
    property p_noGap;
        s_take ##0 !charLast |=> charValid;
    endproperty
    property p_endGap;
        s_take ##0 charLast |=> !charValid;
    endproperty
    property p_start;
        s_start |-> ##2 !charValid ##1 (charValid && chIdx_ff == 4'h0);
    endproperty

    a_marker: assert property (p_marker) else $error("marker bit low");
    a_last: assert property (p_last) else $error("last flag misplaced");
    a_rsvdChar: assert property (p_rsvdChar) else $error("reserved char nonzero");
    a_demodRsvd: assert property (p_demodRsvd) else $error("demod reserved bit set");
    a_tailRsvd: assert property (p_tailRsvd) else $error("reserved bit set");
    a_count: assert property (p_count) else $error("count field bad");
    a_hold: assert property (p_hold) else $error("character not held");
    a_noGap: assert property (p_noGap) else $error("gap in stream");
    a_endGap: assert property (p_endGap) else $error("stream overran");
    a_start: assert property (p_start) else $error("start latency wrong");
endmodule // fault_char_props

bind fault_status_char_packer fault_char_props #(.MAX_STORED(MAX_STORED)) props (
    .core_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .charData, .charValid, .charLast, .charReady
);

/* verif/status_host.sv */
/* Polling host model that takes status characters off the stream.
   Assumes the packer's valid/ready handshake on core_clk. */
`timescale 1ns/1ps
module status_host
    import fault_char_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic [CHAR_WIDTH-1:0] charData,
    input wire logic charValid,
    input wire logic charLast,
    output logic charReady
);
    logic [CHAR_WIDTH-1:0] rxBuf [CHAR_COUNT];
    int rxCount;
    int lastLen;
    int doneCnt;

    // ==========================================================
    // Ready every cycle, or every other cycle to stall the packer
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            charReady <= 1'b0;
        else
            charReady <= slow ? !charReady : 1'b1;
    end

    // A response closes on the flagged character; extras are not stored
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxCount <= 0;
            lastLen <= 0;
            doneCnt <= 0;
        end
        else if (charValid && charReady)
        begin
            if (rxCount < CHAR_COUNT)
                rxBuf[rxCount] <= charData;
            rxCount <= charLast ? 0 : rxCount + 1;
            if (charLast)
            begin
                lastLen <= rxCount + 1;
                doneCnt <= doneCnt + 1;
            end
        end
    end
endmodule // status_host

/* verif/tb.sv */
/* Self-checking bench for the fault status character packer.
   Assumes the bound checker and the status_host model beside it. */
`timescale 1ns/1ps
module tb
    import fault_char_pkg::*;
;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [35:0] live = 36'h0;
    demod_flt_s demodFlt;
    tx_if_flt_s txIfFlt;
    rx_if_flt_s rxIfFlt;
    common_flt_s commonFlt;
    bwd_alarm_s bwdAlarm;
    store_evt_s storeEvt = 4'h0;
    logic [6:0] charData;
    logic charValid;
    logic charLast;
    logic charReady;
    logic irq;
    logic slow = 1'b0;
    logic [3:0] cnt [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
    logic [31:0] rd;
    logic er;
    int failCount = 0;
    int nTests = 0;

    assign {demodFlt, txIfFlt, rxIfFlt, commonFlt, bwdAlarm} = live;

    fault_status_char_packer #(.MAX_STORED(4'ha)) uut (
        .core_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .demodFlt, .txIfFlt, .rxIfFlt, .commonFlt, .bwdAlarm,
        .storeEvt, .charData, .charValid, .charLast, .charReady, .irq
    );
    status_host host (
        .core_clk, .resetn, .slow, .charData, .charValid, .charLast, .charReady
    );

    // ==========================================================
    // Clock and watchdog
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        give_verdict();
    end

    // ==========================================================
    // Shared helpers
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp)
        begin
            failCount++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is sampled high; bounded wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            cmp(32'h1, 32'h0);
    endtask

    // Expected character k, built from the live flags and stored counts
    function automatic logic [6:0] exp_char(int k);
        case (k)
            0: return {1'b1, demodFlt.ifSynthLock, 1'b0, demodFlt.iChannel,
                demodFlt.qChannel, 1'b0, demodFlt.berThreshold};
            2: return {1'b1, txIfFlt.moduleFault, 1'b0, cnt[0]};
            3: return {1'b1, txIfFlt[5:0]};
            5: return {1'b1, rxIfFlt.moduleFault, 1'b0, cnt[1]};
            6: return {1'b1, rxIfFlt[10:6], 1'b0};
            7: return {1'b1, rxIfFlt[5:0]};
            8: return {1'b1, commonFlt.mcModule, 1'b0, cnt[2]};
            9: return {1'b1, commonFlt[9:4]};
            10: return {1'b1, commonFlt[3:0], 2'h0};
            11: return {1'b1, bwdAlarm, cnt[3]};
            default: return 7'h40;
        endcase
    endfunction

    // One response; optionally flips every flag and writes start again mid-stream
    task automatic run_resp(input logic midChange);
        logic [6:0] e [12];
        int d0;
        int n;
        d0 = host.doneCnt;
        apb(1'b1, OFS_CTRL, 32'h1);
        for (int k = 0; k < 12; k++)
            e[k] = exp_char(k);
        n = 0;
        while (midChange && host.rxCount < 2 && n < 100)
        begin
            @(posedge core_clk);
            n++;
        end
        if (midChange)
        begin
            live <= ~live;
            apb(1'b1, OFS_CTRL, 32'h1);
            apb(1'b0, OFS_STATUS, 32'h0);
            cmp(rd[0], 32'h1);
        end
        n = 0;
        while (host.doneCnt == d0 && n < 400)
        begin
            @(posedge core_clk);
            n++;
        end
        repeat (10) @(posedge core_clk);
        cmp(host.doneCnt - d0, 32'h1);
        cmp(host.lastLen, 32'hc);
        for (int k = 0; k < 12; k++)
            cmp({25'h0, host.rxBuf[k]}, {25'h0, e[k]});
    endtask

    task automatic pulse(input int g, input int num);
        repeat (num)
        begin
            @(posedge core_clk);
            storeEvt <= 4'h8 >> g;
            @(posedge core_clk);
            storeEvt <= 4'h0;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b0, OFS_IRQ_MASK, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h3);
        apb(1'b0, OFS_IRQ_MASK, 32'h0);
        cmp(rd, 32'h3);
        apb(1'b1, 12'h020, 32'hffff);
        cmp(er, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        cmp({er, rd[30:0]}, 32'h80000000);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_walk();
        run_resp(1'b0);
        for (int i = 0; i < 36; i++)
        begin
            @(posedge core_clk);
            live <= 36'h1 << i;
            run_resp(1'b0);
        end
        @(posedge core_clk);
        live <= 36'hfffffffff;
        run_resp(1'b0);
        $display("test walk done");
    endtask

    task automatic t_counts();
        pulse(0, 3);
        pulse(1, 12);
        pulse(2, 10);
        pulse(3, 1);
        cnt = '{4'h3, 4'ha, 4'ha, 4'h1};
        apb(1'b0, OFS_COUNTS, 32'h0);
        cmp(rd, 32'h1aa3);
        run_resp(1'b0);
        apb(1'b1, OFS_CTRL, 32'h2);
        cnt = '{4'h0, 4'h0, 4'h0, 4'h0};
        apb(1'b0, OFS_COUNTS, 32'h0);
        cmp(rd, 32'h0);
        $display("test counts done");
    endtask

    task automatic t_coherent();
        @(posedge core_clk);
        slow <= 1'b1;
        live <= 36'h5a5a5a5a5;
        run_resp(1'b1);
        @(posedge core_clk);
        slow <= 1'b0;
        $display("test coherent done");
    endtask

    task automatic t_irq();
        apb(1'b1, OFS_IRQ_STAT, 32'h3);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        run_resp(1'b0);
        cmp(irq, 32'h1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        cmp(rd[0], 32'h1);
        apb(1'b1, OFS_IRQ_STAT, 32'h1);
        repeat (3) @(posedge core_clk);
        cmp(irq, 32'h0);
        live <= 36'h0;
        apb(1'b1, OFS_IRQ_MASK, 32'h2);
        apb(1'b1, OFS_IRQ_STAT, 32'h3);
        live <= 36'h1;
        repeat (3) @(posedge core_clk);
        cmp(irq, 32'h1);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        repeat (3) @(posedge core_clk);
        cmp(irq, 32'h0);
        $display("test irq done");
    endtask

    // ==========================================================
    // Single exit point for the whole run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs();
        t_walk();
        t_counts();
        t_coherent();
        t_irq();
        give_verdict();
    end
endmodule // tb
